// >>> pkg/dp_lane_eq_map.svh
`ifndef DP_LANE_EQ_MAP_SVH
`define DP_LANE_EQ_MAP_SVH

// Register offsets (byte sub-addresses on the register port)
`define OFS_GENERAL          8'h0A
`define OFS_LANE1_LANE3_EQ   8'h10
`define OFS_LANE0_LANE2_EQ   8'h11
`define OFS_SNOOPED_STATE    8'h12
`define OFS_LANE_SB_CTRL     8'h13

// General register fields
`define GEN_EQ_SW_BIT        4
`define GEN_VIDEO_SRC_BIT    3
`define GEN_ORIENT_BIT       2
`define GEN_CFG_HI           1
`define GEN_CFG_LO           0
`define GEN_RESET            8'h01
`define GEN_WMASK            8'h1F

// Equalization fields
`define EQ_HI_MSB            7
`define EQ_HI_LSB            4
`define EQ_LO_MSB            3
`define EQ_LO_LSB            0

// Snooped state fields
`define PWR_MSB              6
`define PWR_LSB              5
`define LCNT_MSB             4
`define LCNT_LSB             0

// Lane and sideband control fields
`define SNOOP_OFF_BIT        7
`define SB_MSB               5
`define SB_LSB               4
`define LANE_OFF_MSB         3
`define LANE_OFF_LSB         0
`define CTRL_WMASK           8'hBF

// Reset values of the video registers
`define DP_REG_RESET         8'h00

// Sink configuration addresses watched on the AUX channel
`define AUX_ADDR_POWER       20'h00600
`define AUX_ADDR_LANES       20'h00101

// Power-state code that keeps the lanes powered
`define PWR_ACTIVE           2'h1

`endif

// >>> pkg/dp_lane_eq_pkg.sv
package dp_lane_eq_pkg;

   typedef logic [7:0] reg_byte_t;
   typedef logic [3:0] eq_level_t;

   typedef enum logic [1:0] {
      SB_BY_CONFIG = 2'b00,
      SB_NEG_SBU1  = 2'b01,
      SB_NEG_SBU2  = 2'b10,
      SB_OPEN      = 2'b11
   } sideband_route_e;

   typedef enum logic [1:0] {
      CFG_ALL_OFF  = 2'b00,
      CFG_USB_ONLY = 2'b01,
      CFG_DP_FOUR  = 2'b10,
      CFG_DP_TWO   = 2'b11
   } config_select_e;

endpackage

// >>> pkg/lane_ctrl_if.sv
`timescale 1ns/10ps
// Carries the lane and sideband control between the register bank and its helpers
interface lane_ctrl_if;
   logic            snoop_off;
   logic [1:0]      power_state;
   logic [4:0]      lane_count;
   logic [3:0]      lane_off;
   logic [3:0]      lane_enable;
   logic            video_enable;
   logic            orientation;
   logic [1:0]      sideband_route_force;
   logic [1:0]      sbu_neg_sel;
   logic [1:0]      sbu_pos_sel;

   modport bank (
      output snoop_off, power_state, lane_count, lane_off, video_enable, orientation,
             sideband_route_force,
      input  lane_enable, sbu_neg_sel, sbu_pos_sel
   );
   modport lanes (
      input  snoop_off, power_state, lane_count, lane_off, video_enable,
      output lane_enable
   );
   modport sideband (
      input  video_enable, orientation, sideband_route_force,
      output sbu_neg_sel, sbu_pos_sel
   );
endinterface

// >>> rtl/dp_lane_enable_calc.sv
`timescale 1ns/10ps
`include "dp_lane_eq_map.svh"
// Works out which video lanes are powered
module dp_lane_enable_calc (
   lane_ctrl_if.lanes ctl
);
   import dp_lane_eq_pkg::*;

   // Lanes wanted by a snooped lane count; counts above four act as four
   function automatic logic [3:0] lanes_for_count(input logic [4:0] cnt);
      logic [3:0] m;
      m = 4'h0;
      if (cnt >= 5'h4) begin
         m = 4'hF;
      end else if (cnt >= 5'h2) begin
         m = 4'h3;
      end else if (cnt == 5'h1) begin
         m = 4'h1;
      end
      return m;
   endfunction

   // Snooping drives lanes from captured state, else the software disables
   always_comb begin
      if (!ctl.video_enable) begin
         ctl.lane_enable = 4'h0;
      end else if (!ctl.snoop_off) begin
         if (ctl.power_state == `PWR_ACTIVE) begin
            ctl.lane_enable = lanes_for_count(ctl.lane_count);
         end else begin
            ctl.lane_enable = 4'h0;
         end
      end else begin
         ctl.lane_enable = ~ctl.lane_off;
      end
   end
endmodule

// >>> rtl/dp_sideband_route.sv
`timescale 1ns/10ps
`include "dp_lane_eq_map.svh"
// Chooses the AUX to sideband switch settings; code 0 open, 1 SBU1, 2 SBU2
module dp_sideband_route (
   lane_ctrl_if.sideband sb
);
   import dp_lane_eq_pkg::*;

   // The force codes win over video enable and orientation
   always_comb begin
      case (sideband_route_e'(sb.sideband_route_force))
         SB_NEG_SBU1: begin
            sb.sbu_neg_sel = 2'h1;
            sb.sbu_pos_sel = 2'h2;
         end
         SB_NEG_SBU2: begin
            sb.sbu_neg_sel = 2'h2;
            sb.sbu_pos_sel = 2'h1;
         end
         SB_OPEN: begin
            sb.sbu_neg_sel = 2'h0;
            sb.sbu_pos_sel = 2'h0;
         end
         default: begin
            if (!sb.video_enable) begin
               sb.sbu_neg_sel = 2'h0;
               sb.sbu_pos_sel = 2'h0;
            end else if (sb.orientation) begin
               sb.sbu_neg_sel = 2'h2;
               sb.sbu_pos_sel = 2'h1;
            end else begin
               sb.sbu_neg_sel = 2'h1;
               sb.sbu_pos_sel = 2'h2;
            end
         end
      endcase
   end
endmodule

// >>> rtl/dp_lane_eq_snoop_regs.sv
`timescale 1ns/10ps
`include "dp_lane_eq_map.svh"
module dp_lane_eq_snoop_regs #(
   parameter int EQ_W = 4
) (
   // Clock and reset
   input  wire logic                        mclk_i,
   input  wire logic                        reset_n_i,
   // Register port from the serial engine
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   input  wire logic [7:0]                  reg_addr_i,
   input  wire dp_lane_eq_pkg::reg_byte_t   reg_wdata_i,
   output logic      [7:0]                  reg_rdata_o,
   // Strap and pin inputs
   input  wire logic [1:0]                  video_eq_strap_pins_i,
   input  wire logic                        video_enable_pin_i,
   // Snooped AUX writes
   input  wire logic                        aux_wr_i,
   input  wire logic [19:0]                 aux_addr_i,
   input  wire logic [7:0]                  aux_data_i,
   // Analog controls
   output logic      [15:0]                 lane_eq_o,
   output logic      [3:0]                  lane_enable_o,
   output logic      [1:0]                  sbu_neg_sel_o,
   output logic      [1:0]                  sbu_pos_sel_o
);
   import dp_lane_eq_pkg::*;

   // Two fields share each byte, so only a four-bit field width can be served
   if (EQ_W != 4) begin : g_bad_eq_width
      $error("EQ_W must be 4");
   end

   lane_ctrl_if ctl ();

   logic       rst_meta;
   logic       rst_n;
   reg_byte_t  general;
   eq_level_t  lane0_eq_level;
   eq_level_t  lane1_eq_level;
   eq_level_t  lane2_eq_level;
   eq_level_t  lane3_eq_level;
   logic [1:0] power_state;
   logic [4:0] lane_count;
   logic       snoop_off;
   logic [1:0] sideband_route_force;
   logic [3:0] lane_off;
   logic       video_enable_cfg;
   logic       video_enable_q;
   logic       video_fall;
   eq_level_t  strap_level;
   logic       eq_software_select;
   logic       video_enable;
   logic       wr_gen;
   logic       wr_eq13;
   logic       wr_eq02;
   logic       wr_ctrl;
   logic [4:0] addr_sel;
   logic [3:0] eq_wstrobe;
   eq_level_t  eq_wvalue [4];
   eq_level_t  eq_held   [4];
   eq_level_t  next_eq   [4];

   // Reset release through two flops so every register leaves reset together
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // One-hot register select shared by the write strobes and the read mux:
   // bit 0 general, 1 lanes 1/3, 2 lanes 0/2, 3 snooped state, 4 lane control
   function automatic logic [4:0] reg_select(input logic [7:0] addr);
      logic [4:0] sel;
      sel = 5'h00;
      if (addr == `OFS_GENERAL) begin
         sel = 5'h01;
      end else if (addr == `OFS_LANE1_LANE3_EQ) begin
         sel = 5'h02;
      end else if (addr == `OFS_LANE0_LANE2_EQ) begin
         sel = 5'h04;
      end else if (addr == `OFS_SNOOPED_STATE) begin
         sel = 5'h08;
      end else if (addr == `OFS_LANE_SB_CTRL) begin
         sel = 5'h10;
      end
      return sel;
   endfunction

   // Write strobes; the sub-address itself is latched by the serial engine,
   // so a write lands at whatever offset the host named first
   assign addr_sel = reg_select(reg_addr_i);
   assign wr_gen   = reg_wr_i & addr_sel[0];
   assign wr_eq13  = reg_wr_i & addr_sel[1];
   assign wr_eq02  = reg_wr_i & addr_sel[2];
   // No strobe for the snooped state offset: its fields are hardware-owned
   assign wr_ctrl  = reg_wr_i & addr_sel[4];

   // General register: override, video source, orientation, config select
   // Bits 7:5 are masked off on write so they always read back zero
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         general <= `GEN_RESET;
      end else if (wr_gen) begin
         general <= reg_wdata_i & `GEN_WMASK;
      end
   end

   assign eq_software_select = general[`GEN_EQ_SW_BIT];
   assign video_enable_cfg   = general[`GEN_CFG_HI];
   // Video enable comes from the pin when the source bit is set
   assign video_enable = general[`GEN_VIDEO_SRC_BIT] ? video_enable_pin_i : video_enable_cfg;
   // Four strap levels spread over the four-bit range
   assign strap_level  = {video_eq_strap_pins_i, video_eq_strap_pins_i};

   // Per-lane write value and strobe in lane order; the upper nibble of each
   // byte is the lower-numbered lane
   assign eq_wvalue[0] = reg_wdata_i[`EQ_HI_MSB:`EQ_HI_LSB];
   assign eq_wvalue[1] = reg_wdata_i[`EQ_HI_MSB:`EQ_HI_LSB];
   assign eq_wvalue[2] = reg_wdata_i[`EQ_LO_MSB:`EQ_LO_LSB];
   assign eq_wvalue[3] = reg_wdata_i[`EQ_LO_MSB:`EQ_LO_LSB];
   assign eq_wstrobe   = {wr_eq13, wr_eq02, wr_eq13, wr_eq02};
   assign eq_held[0]   = lane0_eq_level;
   assign eq_held[1]   = lane1_eq_level;
   assign eq_held[2]   = lane2_eq_level;
   assign eq_held[3]   = lane3_eq_level;

   // Fields mirror the straps every cycle until software takes over, so a
   // write made while the override is off is lost, not deferred
   for (genvar g = 0; g < 4; g++) begin : g_lane_eq
      assign next_eq[g] = !eq_software_select ? strap_level :
                          eq_wstrobe[g]       ? eq_wvalue[g] :
                                                eq_held[g];
   end

   // Equalization registers
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lane0_eq_level <= 4'h0;
         lane1_eq_level <= 4'h0;
         lane2_eq_level <= 4'h0;
         lane3_eq_level <= 4'h0;
      end else begin
         lane0_eq_level <= next_eq[0];
         lane1_eq_level <= next_eq[1];
         lane2_eq_level <= next_eq[2];
         lane3_eq_level <= next_eq[3];
      end
   end

   // Edge detector on the enable register bit, not the pin; it resets low,
   // matching the bit's reset level, so no false fall follows reset
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         video_enable_q <= 1'b0;
      end else begin
         video_enable_q <= video_enable_cfg;
      end
   end
   assign video_fall = video_enable_q && !video_enable_cfg;

   // Power-state capture; the fall clear wins because the link is being torn down
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         power_state <= 2'h0;
      end else if (video_fall) begin
         power_state <= 2'h0;
      end else if (aux_wr_i && aux_addr_i == `AUX_ADDR_POWER) begin
         power_state <= aux_data_i[1:0];
      end
   end

   // Lane-count capture; cleared on the same fall, so with video taken from the enable bit a stale
   // count never powers lanes when video comes back; a fall of the pin clears nothing
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lane_count <= 5'h0;
      end else if (video_fall) begin
         lane_count <= 5'h0;
      end else if (aux_wr_i && aux_addr_i == `AUX_ADDR_LANES) begin
         lane_count <= aux_data_i[4:0];
      end
   end

   // Snoop disable; reset leaves snooping on
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         snoop_off <= 1'b0;
      end else if (wr_ctrl) begin
         snoop_off <= reg_wdata_i[`SNOOP_OFF_BIT];
      end
   end

   // Sideband force code; bit 6 of the byte is not stored and reads zero
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sideband_route_force <= 2'h0;
      end else if (wr_ctrl) begin
         sideband_route_force <= reg_wdata_i[`SB_MSB:`SB_LSB];
      end
   end

   // Per-lane software disables; kept even while snooping so they apply
   // the moment snooping is turned off
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lane_off <= 4'h0;
      end else if (wr_ctrl) begin
         lane_off <= reg_wdata_i[`LANE_OFF_MSB:`LANE_OFF_LSB];
      end
   end

   // Feed the helpers
   assign ctl.snoop_off            = snoop_off;
   assign ctl.power_state          = power_state;
   assign ctl.lane_count           = lane_count;
   assign ctl.lane_off             = lane_off;
   assign ctl.video_enable         = video_enable;
   assign ctl.orientation          = general[`GEN_ORIENT_BIT];
   assign ctl.sideband_route_force = sideband_route_force;

   dp_lane_enable_calc u_lanes (
      .ctl (ctl.lanes)
   );

   dp_sideband_route u_sideband (
      .sb (ctl.sideband)
   );

   // Read mux, registered; unmapped offsets read zero
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         if (addr_sel[0]) begin
            reg_rdata_o <= general;
         end else if (addr_sel[1]) begin
            reg_rdata_o <= {lane1_eq_level, lane3_eq_level};
         end else if (addr_sel[2]) begin
            reg_rdata_o <= {lane0_eq_level, lane2_eq_level};
         end else if (addr_sel[3]) begin
            reg_rdata_o <= {1'b0, power_state, lane_count};
         end else if (addr_sel[4]) begin
            reg_rdata_o <= {snoop_off, 1'b0, sideband_route_force, lane_off};
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

   // Equalization levels to the analog lanes
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lane_eq_o <= 16'h0000;
      end else begin
         lane_eq_o <= {lane3_eq_level, lane2_eq_level, lane1_eq_level, lane0_eq_level};
      end
   end

   // Lane power enables, registered so the analog side sees no decode glitches
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lane_enable_o <= 4'h0;
      end else begin
         lane_enable_o <= ctl.lane_enable;
      end
   end

   // Sideband switch settings
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sbu_neg_sel_o <= 2'h0;
         sbu_pos_sel_o <= 2'h0;
      end else begin
         sbu_neg_sel_o <= ctl.sbu_neg_sel;
         sbu_pos_sel_o <= ctl.sbu_pos_sel;
      end
   end
endmodule

// >>> testbench/dp_lane_eq_snoop_regs_monitor.sv
`timescale 1ns/10ps
// Port-level checker for the video register bank
module dp_lane_eq_snoop_regs_monitor (
   // Clock and reset
   input wire logic                      mclk_i,
   input wire logic                      reset_n_i,
   // Register port
   input wire logic                      reg_wr_i,
   input wire logic                      reg_rd_i,
   input wire logic [7:0]                reg_addr_i,
   input wire dp_lane_eq_pkg::reg_byte_t reg_wdata_i,
   input wire logic [7:0]                reg_rdata_o,
   // Pins and snooped writes
   input wire logic [1:0]                video_eq_strap_pins_i,
   input wire logic                      video_enable_pin_i,
   input wire logic                      aux_wr_i,
   input wire logic [19:0]               aux_addr_i,
   input wire logic [7:0]                aux_data_i,
   // Analog controls
   input wire logic [15:0]               lane_eq_o,
   input wire logic [3:0]                lane_enable_o,
   input wire logic [1:0]                sbu_neg_sel_o,
   input wire logic [1:0]                sbu_pos_sel_o
);
   import dp_lane_eq_pkg::*;
   logic eq_sw;
   default clocking mon_cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // Shadow of the override bit; without it strap mirroring cannot be judged
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         eq_sw <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == 8'h0A) begin
         eq_sw <= reg_wdata_i[4];
      end
   end
   // Reserved bits
   AST_RSV12_ZERO: assert property (reg_rd_i && reg_addr_i == 8'h12 |=> !reg_rdata_o[7])
      else $error("reserved bit of 0x12 read as one");
   AST_RSV13_ZERO: assert property (reg_rd_i && reg_addr_i == 8'h13 |=> !reg_rdata_o[6])
      else $error("reserved bit of 0x13 read as one");
   // Equalization source
   AST_STRAP_MIRROR: assert property ((!eq_sw && $stable(video_eq_strap_pins_i)) [*6]
      |-> lane_eq_o == {8{video_eq_strap_pins_i}}) else $error("eq does not follow straps");
   AST_EQ_REG_10: assert property (eq_sw && reg_wr_i && reg_addr_i == 8'h10 |-> ##2
      lane_eq_o[7:4] == $past(reg_wdata_i[7:4], 2) && lane_eq_o[15:12] == $past(reg_wdata_i[3:0], 2))
      else $error("lane 1 or 3 eq not taken from write");
   AST_EQ_REG_11: assert property (eq_sw && reg_wr_i && reg_addr_i == 8'h11 |-> ##2
      lane_eq_o[3:0] == $past(reg_wdata_i[7:4], 2) && lane_eq_o[11:8] == $past(reg_wdata_i[3:0], 2))
      else $error("lane 0 or 2 eq not taken from write");
   // Sideband force codes
   AST_FORCE_SBU1: assert property (reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[5:4] == 2'b01
      |-> ##2 sbu_neg_sel_o == 2'h1 && sbu_pos_sel_o == 2'h2) else $error("force 01 not routed");
   AST_FORCE_SBU2: assert property (reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[5:4] == 2'b10
      |-> ##2 sbu_neg_sel_o == 2'h2 && sbu_pos_sel_o == 2'h1) else $error("force 10 not routed");
   AST_FORCE_OPEN: assert property (reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[5:4] == 2'b11
      |-> ##2 sbu_neg_sel_o == 2'h0 && sbu_pos_sel_o == 2'h0) else $error("force 11 not open");
   AST_SB_PAIRED: assert property ((sbu_neg_sel_o == 2'h0) == (sbu_pos_sel_o == 2'h0)
      && (sbu_neg_sel_o != sbu_pos_sel_o || sbu_neg_sel_o == 2'h0)) else $error("sideband halves disagree");
endmodule

bind dp_lane_eq_snoop_regs dp_lane_eq_snoop_regs_monitor u_dp_lane_eq_snoop_regs_monitor (
   .mclk_i, .reset_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
   .video_eq_strap_pins_i, .video_enable_pin_i, .aux_wr_i, .aux_addr_i, .aux_data_i,
   .lane_eq_o, .lane_enable_o, .sbu_neg_sel_o, .sbu_pos_sel_o
);

// >>> testbench/aux_source_model.sv
`timescale 1ns/10ps
// Video source issuing sink configuration writes on the AUX channel
module aux_source_model (
   // Clock
   input  wire logic   mclk_i,
   // Snooped write
   output logic        aux_wr_o,
   output logic [19:0] aux_addr_o,
   output logic [7:0]  aux_data_o
);
   // Idle at time zero
   initial begin
      aux_wr_o = 1'b0;
      aux_addr_o = 20'h00000;
      aux_data_o = 8'h00;
   end
   // One write after gap idle cycles; lines then invert so nothing stale can match
   task automatic send(input logic [19:0] a, input logic [7:0] d, input int gap);
      repeat (gap) @(posedge mclk_i);
      @(posedge mclk_i);
      aux_wr_o <= 1'b1;
      aux_addr_o <= a;
      aux_data_o <= d;
      @(posedge mclk_i);
      aux_wr_o <= 1'b0;
      aux_addr_o <= ~a;
      aux_data_o <= ~d;
   endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
// Register bank bench: register port tasks plus an AUX source model
module tb_top;
   import dp_lane_eq_pkg::*;
   logic        mclk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   reg_byte_t   reg_wdata_i = 8'h00;
   logic [7:0]  reg_rdata_o;
   logic [1:0]  straps = 2'h0;
   logic        video_pin = 1'b0;
   logic        aux_wr;
   logic [19:0] aux_addr;
   logic [7:0]  aux_data;
   logic [15:0] lane_eq_o;
   logic [3:0]  lane_enable_o;
   logic [1:0]  sbu_neg;
   logic [1:0]  sbu_pos;
   int          errors = 0;
   int          compares = 0;

   // Clock
   always #5 mclk_i = ~mclk_i;

   dp_lane_eq_snoop_regs u_dp_lane_eq_snoop_regs (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .video_eq_strap_pins_i(straps), .video_enable_pin_i(video_pin), .aux_wr_i(aux_wr),
      .aux_addr_i(aux_addr), .aux_data_i(aux_data), .lane_eq_o(lane_eq_o),
      .lane_enable_o(lane_enable_o), .sbu_neg_sel_o(sbu_neg), .sbu_pos_sel_o(sbu_pos)
   );
   aux_source_model u_aux_source_model (
      .mclk_i(mclk_i), .aux_wr_o(aux_wr), .aux_addr_o(aux_addr), .aux_data_o(aux_data)
   );

   // Counted comparison
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=0x%0h exp=0x%0h", $time, seen, exp);
      end
   endtask
   // Register port cycles: one strobe pulse each
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(posedge mclk_i);
      #1 chk(16'(reg_rdata_o), 16'(exp));
   endtask
   // Outputs lag a write by two cycles; four leaves margin
   task automatic settle;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask
   task automatic t_reset;
      rchk(8'h10, 8'h00);
      rchk(8'h11, 8'h00);
      rchk(8'h12, 8'h00);
      rchk(8'h13, 8'h00);
      rchk(8'h0A, 8'h01);
      chk(16'(lane_enable_o), 16'h0);
   endtask
   // Read-only, reserved and unmapped places
   task automatic t_access;
      wr(8'h13, 8'hFF);
      rchk(8'h13, 8'hBF);
      wr(8'h12, 8'hFF);
      rchk(8'h12, 8'h00);
      wr(8'h40, 8'h5A);
      rchk(8'h40, 8'h00);
      wr(8'h0A, 8'hFF);
      rchk(8'h0A, 8'h1F);
      wr(8'h0A, 8'h01);
      wr(8'h13, 8'h00);
   endtask
   task automatic t_eq;
      @(posedge mclk_i) straps <= 2'b10;
      settle();
      rchk(8'h10, 8'hAA);
      wr(8'h11, 8'h12);
      rchk(8'h11, 8'hAA);
      wr(8'h0A, 8'h11);
      wr(8'h10, 8'h5C);
      wr(8'h11, 8'h37);
      rchk(8'h10, 8'h5C);
      rchk(8'h11, 8'h37);
      chk(lane_eq_o, 16'hC753);
      wr(8'h0A, 8'h01);
      settle();
      chk(lane_eq_o, 16'hAAAA);
   endtask
   task automatic t_snoop;
      logic [3:0] lanes [5] = '{4'h0, 4'h1, 4'h3, 4'h3, 4'hF};
      wr(8'h0A, 8'h02);
      u_aux_source_model.send(20'h00600, 8'h01, 0);
      for (int i = 0; i < 5; i++) begin
         u_aux_source_model.send(20'h00101, 8'(i), i);
         settle();
         rchk(8'h12, 8'h20 | 8'(i));
         chk(16'(lane_enable_o), 16'(lanes[i]));
      end
      u_aux_source_model.send(20'h00600, 8'h02, 3);
      u_aux_source_model.send(20'h00602, 8'h01, 0);
      settle();
      rchk(8'h12, 8'h44);
      chk(16'(lane_enable_o), 16'h0);
      u_aux_source_model.send(20'h00600, 8'h01, 0);
      wr(8'h13, 8'h05);
      settle();
      chk(16'(lane_enable_o), 16'hF);
      wr(8'h13, 8'h85);
      settle();
      chk(16'(lane_enable_o), 16'hA);
      wr(8'h13, 8'h00);
      wr(8'h0A, 8'h01);
      settle();
      rchk(8'h12, 8'h00);
      chk(16'(lane_enable_o), 16'h0);
   endtask
   // Sideband force codes with the video path off, then the default routing
   task automatic t_sideband;
      logic [3:0] exp [4] = '{4'h0, 4'h6, 4'h9, 4'h0};
      for (int c = 0; c < 4; c++) begin
         wr(8'h13, {2'b00, 2'(c), 4'h0});
         settle();
         chk(16'({sbu_neg, sbu_pos}), 16'(exp[c]));
      end
      wr(8'h13, 8'h00);
      wr(8'h0A, 8'h02);
      settle();
      chk(16'({sbu_neg, sbu_pos}), 16'h6);
      wr(8'h0A, 8'h06);
      settle();
      chk(16'({sbu_neg, sbu_pos}), 16'h9);
      // Force 01 must win over video on with orientation 1
      wr(8'h13, 8'h10);
      settle();
      chk(16'({sbu_neg, sbu_pos}), 16'h6);
      // Video enable taken from the pin
      wr(8'h13, 8'h00);
      wr(8'h0A, 8'h08);
      @(posedge mclk_i) video_pin <= 1'b1;
      settle();
      chk(16'({sbu_neg, sbu_pos}), 16'h6);
      @(posedge mclk_i) video_pin <= 1'b0;
      settle();
      chk(16'({sbu_neg, sbu_pos}), 16'h0);
   endtask
   // Single exit point
   task automatic close_out;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog: the whole run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      close_out();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_reset();
      t_access();
      t_eq();
      t_snoop();
      t_sideband();
      close_out();
   end
endmodule
